// File: hdl/wcrr_pkg.sv
// shared types and constants for the write cache reallocation report block
package wcrr_pkg;

    // ****************************************************************
    // widths and fixed values
    // ****************************************************************
    localparam int LBA_W = 28;
    localparam int DD_W = 16;
    localparam int CAND_N = 4;
    localparam int CAND_IW = 2;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [CAND_IW-1:0] PTR_ONE = 2'h1;
    localparam logic [CAND_IW-1:0] PTR_ZERO = 2'h0;

    typedef logic [LBA_W-1:0] wcrr_lba_t;

    // ****************************************************************
    // state and operation encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_XFER = 2'h1,
        H_EXEC = 2'h3,
        H_MWAIT = 2'h2
    } wcrr_host_e;

    typedef enum logic [1:0] {
        B_IDLE = 2'h0,
        B_WRITE = 2'h1,
        B_REMAP = 2'h3
    } wcrr_bg_e;

    typedef enum logic {
        MED_WRITE = 1'b0,
        MED_REMAP = 1'b1
    } wcrr_op_e;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic is_write;
        wcrr_lba_t lba;
    } wcrr_cmd_s;

    typedef struct packed {
        wcrr_op_e op;
        wcrr_lba_t lba;
    } wcrr_med_s;

    typedef struct packed {
        logic feat_hit;
        logic [15:0] feat_mask;
        logic word_hit;
        logic [7:0] word_ofs;
    } wcrr_ovl_s;

    typedef struct packed {
        logic [7:0] cyl_high;
        logic [7:0] cyl_low;
        logic [7:0] sect_num;
    } wcrr_res_s;

endpackage

// File: hdl/wcrr_core.sv
// write completion, auto reallocation and error reporting engine
`timescale 1ns/1ps
module wcrr_core (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cache_en,
    input wire logic cmd_valid,
    input wire wcrr_pkg::wcrr_cmd_s cmd,
    output logic cmd_ready,
    input wire logic data_done,
    input wire logic exec_done,
    output logic cmp_valid,
    output logic cmp_err,
    input wire logic xfer_8bit,
    input wire logic [wcrr_pkg::DD_W-1:0] dd_in,
    input wire logic dd_strobe,
    output logic [wcrr_pkg::DD_W-1:0] buf_wdata,
    output logic buf_wvalid,
    output logic med_valid,
    output wcrr_pkg::wcrr_med_s med_req,
    input wire logic med_done,
    input wire logic med_err,
    input wire logic rd_fail,
    input wire logic rd_recovered,
    input wire wcrr_pkg::wcrr_lba_t rd_lba,
    output logic rd_err_valid,
    input wire logic ovl_abort,
    input wire wcrr_pkg::wcrr_ovl_s ovl_info,
    output wcrr_pkg::wcrr_res_s ovl_result
);
    import wcrr_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    wcrr_host_e h_st_r;
    wcrr_bg_e bg_st_r;
    wcrr_med_s med_req_r;
    wcrr_lba_t wr_lba_r;
    wcrr_lba_t rec_lba_r;
    wcrr_res_s ovl_res_r;
    logic bg_bkgnd_r;
    logic cur_err_r;
    logic defer_err_r;
    logic rec_pend_r;
    logic cmp_valid_r;
    logic cmp_err_r;
    logic rd_err_r;
    logic buf_wvalid_r;
    logic [DD_W-1:0] buf_wdata_r;
    logic [CAND_N-1:0] cand_v_r;
    wcrr_lba_t cand_lba_r [CAND_N];
    logic [CAND_IW-1:0] cand_ptr_r;

    logic accept, host_running, wr_launch, rec_launch, launch;
    logic launch_hit, rd_known, bg_done, bg_fail, bg_fail_bk;
    logic comp, comp_err;
    wcrr_lba_t launch_lba;

    // ****************************************************************
    // handshake and event decode
    // ****************************************************************
    // writes wait for an idle media engine: a single buffer slot only
    assign cmd_ready = (h_st_r == H_IDLE) &&
        (!cmd.is_write || (bg_st_r == B_IDLE && !rec_pend_r));
    assign accept = cmd_valid && cmd_ready;
    assign host_running = (h_st_r == H_XFER) || (h_st_r == H_EXEC);
    assign wr_launch = (h_st_r == H_XFER) && data_done;
    // recovered remaps yield to a write in its data phase
    assign rec_launch = rec_pend_r && (bg_st_r == B_IDLE) &&
        (h_st_r != H_XFER) && !wr_launch;
    assign launch = wr_launch || rec_launch;
    assign launch_lba = wr_launch ? wr_lba_r : rec_lba_r;
    assign bg_done = med_done && ((bg_st_r == B_WRITE && !med_err) ||
        bg_st_r == B_REMAP);
    assign bg_fail = med_done && (bg_st_r == B_REMAP) && med_err;
    assign bg_fail_bk = bg_fail && bg_bkgnd_r;

    // candidate lookups for launch and for read failures
    always_comb begin
        launch_hit = 1'b0;
        rd_known = 1'b0;
        for (int i = 0; i < CAND_N; i++) begin
            if (cand_v_r[i] && cand_lba_r[i] == launch_lba) begin
                launch_hit = 1'b1;
            end
            if (cand_v_r[i] && cand_lba_r[i] == rd_lba) begin
                rd_known = 1'b1;
            end
        end
    end

    // ****************************************************************
    // host command sequencing
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            h_st_r <= H_IDLE;
        end else begin
            unique case (h_st_r)
                H_IDLE: begin
                    if (accept) begin
                        h_st_r <= cmd.is_write ? H_XFER : H_EXEC;
                    end
                end
                H_XFER: begin
                    if (data_done) begin
                        h_st_r <= cache_en ? H_IDLE : H_MWAIT;
                    end
                end
                H_EXEC: begin
                    if (exec_done) begin
                        h_st_r <= H_IDLE;
                    end
                end
                H_MWAIT: begin
                    if (bg_done) begin
                        h_st_r <= H_IDLE;
                    end
                end
            endcase
        end
    end

    // latch the target of the write being transferred
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_lba_r <= '0;
        end else if (accept && cmd.is_write) begin
            wr_lba_r <= cmd.lba;
        end
    end

    // completion decode: cached at buffer fill, uncached after media
    always_comb begin
        comp = 1'b0;
        comp_err = 1'b0;
        if (wr_launch && cache_en) begin
            comp = 1'b1;
            comp_err = cur_err_r || bg_fail_bk;
        end else if (h_st_r == H_EXEC && exec_done) begin
            comp = 1'b1;
            comp_err = cur_err_r || bg_fail_bk;
        end else if (h_st_r == H_MWAIT && bg_done) begin
            comp = 1'b1;
            comp_err = cur_err_r || bg_fail;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_valid_r <= 1'b0;
            cmp_err_r <= 1'b0;
        end else begin
            cmp_valid_r <= comp;
            cmp_err_r <= comp_err;
        end
    end

    // ****************************************************************
    // error attachment
    // ****************************************************************
    // a failure seen with a command running belongs to it; an accept
    // in the same cycle takes both the held and the fresh failure
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_err_r <= 1'b0;
        end else if (accept) begin
            cur_err_r <= defer_err_r || bg_fail_bk;
        end else if (host_running && bg_fail_bk) begin
            cur_err_r <= 1'b1;
        end
    end

    // held failure: a same-cycle accept wins over the set and takes the fresh failure itself
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            defer_err_r <= 1'b0;
        end else if (bg_fail_bk && !host_running && !accept &&
                     h_st_r != H_MWAIT) begin
            defer_err_r <= 1'b1;
        end else if (accept) begin
            defer_err_r <= 1'b0;
        end
    end

    // ****************************************************************
    // media engine
    // ****************************************************************
    // remapping after a write failure has no disable path at all
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bg_st_r <= B_IDLE;
            med_req_r <= '0;
            bg_bkgnd_r <= 1'b0;
        end else begin
            unique case (bg_st_r)
                B_IDLE: begin
                    if (launch) begin
                        med_req_r.lba <= launch_lba;
                        bg_bkgnd_r <= rec_launch || cache_en;
                        if (launch_hit || rec_launch) begin
                            bg_st_r <= B_REMAP;
                            med_req_r.op <= MED_REMAP;
                        end else begin
                            bg_st_r <= B_WRITE;
                            med_req_r.op <= MED_WRITE;
                        end
                    end
                end
                B_WRITE: begin
                    if (med_done && med_err) begin
                        bg_st_r <= B_REMAP;
                        med_req_r.op <= MED_REMAP;
                    end else if (med_done) begin
                        bg_st_r <= B_IDLE;
                    end
                end
                B_REMAP: begin
                    if (med_done) begin
                        bg_st_r <= B_IDLE;
                    end
                end
                default: begin
                    bg_st_r <= B_IDLE;
                end
            endcase
        end
    end

    // recovered sector waiting for the engine; a second one arriving
    // while one still waits is dropped, the media retries it later
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rec_pend_r <= 1'b0;
            rec_lba_r <= '0;
        end else if (rd_recovered && (!rec_pend_r || rec_launch)) begin
            // a fresh sector beats the clear of the one just launched
            rec_pend_r <= 1'b1;
            rec_lba_r <= rd_lba;
        end else if (rec_launch) begin
            rec_pend_r <= 1'b0;
        end
    end

    // ****************************************************************
    // remap candidates from unrecovered reads
    // ****************************************************************
    // insertion beats a same-cycle clear of the same location
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cand_v_r <= '0;
            cand_ptr_r <= PTR_ZERO;
            for (int i = 0; i < CAND_N; i++) begin
                cand_lba_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < CAND_N; i++) begin
                if (bg_done && !med_err &&
                    cand_lba_r[i] == med_req_r.lba) begin
                    cand_v_r[i] <= 1'b0;
                end
            end
            if (rd_fail && !rd_known) begin
                cand_v_r[cand_ptr_r] <= 1'b1;
                cand_lba_r[cand_ptr_r] <= rd_lba;
                cand_ptr_r <= cand_ptr_r + PTR_ONE;
            end
        end
    end

    // error report toward the host for a failed read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_err_r <= 1'b0;
        end else begin
            rd_err_r <= rd_fail;
        end
    end

    // ****************************************************************
    // host data lanes and overlay result
    // ****************************************************************
    // narrow transfers use only the low eight lines; upper lanes zeroed
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_wvalid_r <= 1'b0;
            buf_wdata_r <= ZERO_WORD;
        end else begin
            buf_wvalid_r <= dd_strobe && (h_st_r == H_XFER);
            if (dd_strobe) begin
                buf_wdata_r <= xfer_8bit ? {ZERO_BYTE, dd_in[7:0]}
                                         : dd_in;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovl_res_r <= '0;
        end else if (ovl_abort) begin
            ovl_res_r.cyl_low <= ovl_info.feat_hit ?
                ovl_info.feat_mask[15:8] : ZERO_BYTE;
            ovl_res_r.sect_num <= ovl_info.feat_hit ?
                ovl_info.feat_mask[7:0] : ZERO_BYTE;
            ovl_res_r.cyl_high <= ovl_info.word_hit ?
                ovl_info.word_ofs : ZERO_BYTE;
        end
    end

    assign cmp_valid = cmp_valid_r;
    assign cmp_err = cmp_err_r;
    assign buf_wdata = buf_wdata_r;
    assign buf_wvalid = buf_wvalid_r;
    assign med_valid = (bg_st_r != B_IDLE);
    assign med_req = med_req_r;
    assign rd_err_valid = rd_err_r;
    assign ovl_result = ovl_res_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_OVL_BITS: assert property (@(posedge core_clk)
        disable iff (!rst_n) ovl_abort |=>
        {ovl_result.cyl_low, ovl_result.sect_num} ==
        ($past(ovl_info.feat_hit) ? $past(ovl_info.feat_mask) : ZERO_WORD))
        else $error("overlay feature bits wrong");
    AST_OVL_WORD: assert property (@(posedge core_clk)
        disable iff (!rst_n) ovl_abort |=> ovl_result.cyl_high ==
        ($past(ovl_info.word_hit) ? $past(ovl_info.word_ofs) : ZERO_BYTE))
        else $error("overlay word offset wrong");
    AST_CACHED_CMP: assert property (@(posedge core_clk)
        disable iff (!rst_n) h_st_r == H_XFER && data_done && cache_en
        |=> cmp_valid && med_valid)
        else $error("cached write not completed at buffer fill");
    AST_REMAP_ERR: assert property (@(posedge core_clk)
        disable iff (!rst_n) bg_st_r == B_WRITE && med_done && med_err |=>
        med_valid && med_req.op == MED_REMAP && $stable(med_req.lba))
        else $error("write error not remapped");
    AST_EXEC_ERR: assert property (@(posedge core_clk)
        disable iff (!rst_n) host_running && bg_fail_bk |=> cur_err_r)
        else $error("failure not held for running command");
    AST_EXEC_CMP: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        h_st_r == H_EXEC && exec_done && (cur_err_r || bg_fail_bk)
        |=> cmp_valid && cmp_err)
        else $error("failure not reported on running command");
    AST_DEFER: assert property (@(posedge core_clk)
        disable iff (!rst_n) accept && defer_err_r |=>
        cur_err_r && !defer_err_r)
        else $error("held failure not passed to next command");
    AST_UNCACHED: assert property (@(posedge core_clk)
        disable iff (!rst_n) h_st_r == H_MWAIT && !bg_done |=> !cmp_valid)
        else $error("uncached write completed before media");
    AST_RD_FAIL: assert property (@(posedge core_clk)
        disable iff (!rst_n) rd_fail |=> rd_err_valid && (|cand_v_r))
        else $error("read failure not reported or recorded");
    AST_CAND_HIT: assert property (@(posedge core_clk)
        disable iff (!rst_n) wr_launch && launch_hit |=>
        med_req.op == MED_REMAP)
        else $error("candidate write not remapped");
    AST_REC: assert property (@(posedge core_clk)
        disable iff (!rst_n) rec_launch |=>
        bg_st_r == B_REMAP && med_req.lba == $past(rec_lba_r))
        else $error("recovered sector not remapped");
    AST_NARROW: assert property (@(posedge core_clk)
        disable iff (!rst_n) dd_strobe && xfer_8bit |=>
        buf_wdata[15:8] == ZERO_BYTE)
        else $error("narrow transfer drove upper lanes");
endmodule

// File: tb/wcrr_media_model.sv
// media side responder for the reallocation engine bench
`timescale 1ns/1ps
module wcrr_media_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic med_valid,
    input wire wcrr_pkg::wcrr_med_s med_req,
    input wire logic err_w,
    input wire logic err_r,
    input wire logic [3:0] dly,
    output logic med_done,
    output logic med_err
);
    import wcrr_pkg::*;
    logic [3:0] cnt_r;

    // ****************************************************************
    // op timing and fault injection
    // ****************************************************************
    // err outside done is noise so the engine never leans on a stale level
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            med_done <= 1'b0;
            med_err <= 1'b0;
        end else begin
            med_done <= 1'b0;
            med_err <= 1'($urandom);
            if (med_valid && !med_done) begin
                if (cnt_r >= dly) begin
                    med_done <= 1'b1;
                    med_err <= (med_req.op == MED_WRITE) ? err_w : err_r;
                    cnt_r <= 4'h0;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end
endmodule

// File: tb/write_cache_reallocation_report_tb.sv
// self-checking bench for the reallocation and reporting engine
`timescale 1ns/1ps
module write_cache_reallocation_report_tb;
    import wcrr_pkg::*;
    logic core_clk = 0, rst_n = 0, cache_en = 1, cmd_valid = 0;
    logic data_done = 0, exec_done = 0, xfer_8bit = 0, dd_strobe = 0;
    logic rd_fail = 0, rd_recovered = 0, ovl_abort = 0;
    logic err_w = 0, err_r = 0, saw_done = 0;
    logic cmd_ready, cmp_valid, cmp_err, buf_wvalid, med_valid, med_done;
    logic med_err, rd_err_valid;
    logic [3:0] dly = 4'h6;
    logic [DD_W-1:0] dd_in = '0, buf_wdata;
    wcrr_cmd_s cmd = '0;
    wcrr_med_s med_req;
    wcrr_lba_t rd_lba = '0, la, lb, last_lba;
    wcrr_op_e last_op;
    wcrr_ovl_s ovl_info = '0;
    wcrr_res_s ovl_result;
    int n_errors = 0, num_checks = 0, cyc = 0;

    wcrr_core dut (.core_clk(core_clk), .rst_n(rst_n), .cache_en(cache_en),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .data_done(data_done), .exec_done(exec_done), .cmp_valid(cmp_valid),
        .cmp_err(cmp_err), .xfer_8bit(xfer_8bit), .dd_in(dd_in),
        .dd_strobe(dd_strobe), .buf_wdata(buf_wdata),
        .buf_wvalid(buf_wvalid), .med_valid(med_valid), .med_req(med_req),
        .med_done(med_done), .med_err(med_err), .rd_fail(rd_fail),
        .rd_recovered(rd_recovered), .rd_lba(rd_lba),
        .rd_err_valid(rd_err_valid), .ovl_abort(ovl_abort),
        .ovl_info(ovl_info), .ovl_result(ovl_result));
    wcrr_media_model media (.core_clk(core_clk), .rst_n(rst_n),
        .med_valid(med_valid), .med_req(med_req), .err_w(err_w),
        .err_r(err_r), .dly(dly), .med_done(med_done), .med_err(med_err));

    // ****************************************************************
    // clock, hang guard and media watcher
    // ****************************************************************
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    // op seen at completion; read later, so no same-edge race
    always @(negedge core_clk) if (med_done === 1'b1) begin
        last_op <= med_req.op;
        last_lba <= med_req.lba;
        saw_done <= 1'b1;
    end

    // ****************************************************************
    // expectations and shared tasks
    // ****************************************************************
    function automatic wcrr_res_s exp_ovl(wcrr_ovl_s o);
        exp_ovl.cyl_high = o.word_hit ? o.word_ofs : ZERO_BYTE;
        {exp_ovl.cyl_low, exp_ovl.sect_num} = o.feat_hit ? o.feat_mask
                                                          : ZERO_WORD;
    endfunction
    function automatic logic [DD_W-1:0] exp_bw(logic [DD_W-1:0] d,
                                                logic n8);
        return n8 ? {ZERO_BYTE, d[7:0]} : d;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic issue(input logic w, input wcrr_lba_t a);
        @(negedge core_clk);
        cmd_valid = 1;
        cmd.is_write = w;
        cmd.lba = a;
        #1;
        while (cmd_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        cmd_valid = 0;
    endtask
    task automatic finish_cmd(input logic wr);
        @(negedge core_clk);
        if (wr) data_done = 1;
        else exec_done = 1;
        @(negedge core_clk);
        data_done = 0;
        exec_done = 0;
    endtask
    task automatic wait_cmp(input logic e);
        for (int i = 0; i < 40 && cmp_valid !== 1'b1; i++)
            @(negedge core_clk);
        chk(cmp_valid, 1);
        chk(cmp_err, e);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 80 && med_valid !== 1'b0; i++)
            @(negedge core_clk);
        @(negedge core_clk);
    endtask
    // mixed widths: 8-bit words must reach the buffer on the low lines
    task automatic wcached(input wcrr_lba_t a, input logic e);
        logic [DD_W-1:0] d;
        issue(1, a);
        for (int i = 0; i < 3; i++) begin
            @(negedge core_clk);
            d = DD_W'($urandom);
            xfer_8bit = 1'($urandom);
            dd_in = d;
            dd_strobe = 1;
            @(negedge core_clk);
            dd_strobe = 0;
            chk(buf_wdata, exp_bw(d, xfer_8bit));
            chk(buf_wvalid, 1);
        end
        finish_cmd(1);
        wait_cmp(e);
    endtask
    task automatic nonwrite(input logic e);
        issue(0, '0);
        finish_cmd(0);
        wait_cmp(e);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(84));
        repeat (16) @(negedge core_clk);
        rst_n = 1;
        // overlay abort: all four hit combinations, then random
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk);
            ovl_info = wcrr_ovl_s'($bits(wcrr_ovl_s)'($urandom));
            if (i < 4) {ovl_info.word_hit, ovl_info.feat_hit} = 2'(i);
            ovl_abort = 1;
            @(negedge core_clk);
            ovl_abort = 0;
            chk(ovl_result, exp_ovl(ovl_info));
        end
        $display("test overlay done");
        // cached write completes while media still busy, error remaps
        la = wcrr_lba_t'($urandom);
        err_w = 1;
        wcached(la, 0);
        chk(med_valid, 1);
        chk(med_req.op, MED_WRITE);
        chk(cmd_ready, 0);
        wait_idle();
        chk(cmd_ready, 1);
        chk(last_op, MED_REMAP);
        chk(last_lba, la);
        $display("test cached done");
        // remap failure while a non-write runs lands on that command
        err_r = 1;
        wcached(la + 1, 0);
        issue(0, '0);
        wait_idle();
        finish_cmd(0);
        wait_cmp(1);
        // remap failure while idle lands on the next command only
        wcached(la + 2, 0);
        wait_idle();
        nonwrite(1);
        err_w = 0;
        err_r = 0;
        nonwrite(0);
        $display("test deferred done");
        // uncached write waits for media and its remap
        cache_en = 0;
        err_w = 1;
        saw_done = 0;
        wcached(la + 3, 0);
        chk(saw_done, 1);
        chk(last_op, MED_REMAP);
        chk(med_valid, 0);
        // uncached remap failure belongs to that write, never deferred
        err_r = 1;
        wcached(wcrr_lba_t'(la + 4), 1);
        err_r = 0;
        err_w = 0;
        cache_en = 1;
        nonwrite(0);
        $display("test uncached done");
        // unrecovered read leaves a candidate that a later write remaps
        lb = wcrr_lba_t'($urandom);
        @(negedge core_clk);
        rd_lba = lb;
        rd_fail = 1;
        @(negedge core_clk);
        rd_fail = 0;
        chk(rd_err_valid, 1);
        wcached(lb + 7, 0);
        wait_idle();
        wcached(lb, 0);
        chk(med_req.op, MED_REMAP);
        chk(med_req.lba, lb);
        wait_idle();
        wcached(lb, 0);
        chk(med_req.op, MED_WRITE);
        wait_idle();
        $display("test candidate done");
        // recovered read is remapped in the background
        @(negedge core_clk);
        rd_lba = wcrr_lba_t'(lb + 9);
        rd_recovered = 1;
        @(negedge core_clk);
        rd_recovered = 0;
        for (int i = 0; i < 20 && med_valid !== 1'b1; i++)
            @(negedge core_clk);
        chk(med_req.op, MED_REMAP);
        chk(med_req.lba, wcrr_lba_t'(lb + 9));
        wait_idle();
        // the idle wait above leaves the media engine idle before the verdict; the last non-write does not wait for media
        nonwrite(0);
        $display("test recovered done");
        give_verdict();
    end
endmodule
